// ===== inc/phy_pages_map.vh
// register indices, field positions and reset values of the paged phy registers
`ifndef PHY_PAGES_MAP_VH
`define PHY_PAGES_MAP_VH

// register indices; byte address is four times the index
`define IDX_PAGE_SEL        6'h07
`define IDX_PAGED_LO        6'h08
`define IDX_COMPLIANCE      6'h08
`define IDX_IDENT_RSVD      6'h09
`define IDX_OUI_HIGH        6'h0a
`define IDX_OUI_MIDDLE      6'h0b
`define IDX_OUI_LOW         6'h0c
`define IDX_PART_HIGH       6'h0d
`define IDX_PART_MIDDLE     6'h0e
`define IDX_PART_LOW        6'h0f
`define IDX_SOFT_RESET      6'h0e
`define IDX_PORT_CTRL       6'h10
`define IDX_PORT_STAT       6'h11
`define IDX_PORT_LINK       6'h12
`define IDX_IRQ_STAT        6'h13
`define IDX_IRQ_MASK        6'h14

// page chooser values
`define PAGE_IDENT          3'h1
`define PAGE_VENDOR         3'h7

// field positions
`define PAGE_SEL_LSB        0
`define CTRL_SLEEP_LSB      0
`define CTRL_DEEP_LSB       4
`define STAT_SLEEP_LSB      0
`define STAT_LOOP_LSB       4
`define STAT_STANDBY_LSB    8
`define LINK_CON_LSB        0
`define LINK_RECEIVE_OK_FLAG_LSB       4
`define LINK_DIS_LSB        8
`define SWR_BIT             7
`define IRQ_LOOP_BIT        0
`define IRQ_SLEEP_BIT       1
`define IRQ_DISC_BIT        2

// reset and constant values
`define RST_PAGE_SEL        3'h0
`define RST_DEEP_OFF        3'h0
`define RST_IRQ_MASK        3'h0
`define COMPLIANCE_VALUE    8'h02

`endif

// ===== hw/phy_port_and_vendor_pages.v
// paged port flags, identification page and vendor page behind an ahb-lite slave
//
// Behaviour
// - reset loads sleep allow from sleep pin
// - sleep allow writable per port
// - port sleeps only when sleep allowed
// - loop break reads 1 while loop-disabled
// - loop break cleared on bus reset, disconnect
// - standby flag mirrors standby state
// - deep off ignored unless port disabled
// - deep off stops tones on disabled port
// - deep off forces connected, receive-ok to 0
// - page value 1 maps identification page
// - page value 7 maps vendor page
// - compliance register reads 02h
// - maker oui msb at paged 1010b
// - part code msb at paged 1101b
// - writing hard reset bit resets device
// - hard reset bit always reads 0
`timescale 1ns/1ps
`default_nettype none
`include "phy_pages_map.vh"

module phy_port_and_vendor_pages #(
    parameter [23:0] MAKER_OUI = 24'h5a_c3_96, // arbitrary value
    parameter [23:0] PART_CODE = 24'h3c_69_a5  // arbitrary value
) (
    input  wire        ref_clk,
    input  wire        nrst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    // straps and port state
    input  wire        sleep_default_pin,
    input  wire        bus_reset,
    input  wire [2:0]  port_disabled,
    input  wire [2:0]  port_connected_raw,
    input  wire [2:0]  port_receive_ok_raw,
    input  wire [2:0]  port_loop_detect,
    input  wire [2:0]  port_standby,
    input  wire [2:0]  port_sleep_req,
    // results toward the port logic
    output wire [2:0]  port_sleeping,
    output wire [2:0]  port_tone_enable,
    output wire [2:0]  port_connected,
    output wire [2:0]  receive_ok_flag,
    output wire        device_hard_reset,
    output wire        irq
);

    // internal reset: pin or software hard reset
    reg         swr_pulse_ff;      // one-cycle software reset request
    wire        rst_int;           // combined active-high reset

    assign rst_int = !nrst || swr_pulse_ff;

    // the pulse clears itself through rst_int, so it lasts one cycle;
    // bus tracking answers to the pin alone, so a software reset
    // never leaves the bus handshake half way

    // ------------------------------------------------------------
    // ahb-lite address and data phase tracking
    // ------------------------------------------------------------
    reg         wr_pend_ff;        // write data phase pending
    reg         rd_pend_ff;        // read data phase, first cycle
    reg  [5:0]  idx_ff;            // latched register index
    reg         hit_ff;            // latched address within map window
    reg  [31:0] rdata_ff;          // registered read data
    wire        take;              // transfer accepted this edge
    wire        wr_now;            // write data valid this cycle
    wire        rd_cap;            // read data captured this cycle

    // a stalled address phase is taken once, on the edge whose
    // hready completes it
    assign take   = hsel && htrans[1] && hready;
    assign wr_now = wr_pend_ff;
    assign rd_cap = rd_pend_ff;

    // reads insert one wait so they see every earlier write
    assign hreadyout = !rd_pend_ff;
    // no error response: unmapped or reserved accesses end okay,
    // so a probing driver never traps on this block
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    // address phase capture
    // hsize is not decoded: every register is one aligned word
    // an address above the window still completes, as a no-op
    always @(posedge ref_clk) begin
        if (!nrst) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff     <= 6'h00;
            hit_ff     <= 1'b0;
        end else begin
            wr_pend_ff <= take && hwrite;
            rd_pend_ff <= take && !hwrite;
            if (take) begin
                idx_ff <= haddr[7:2];
                hit_ff <= (haddr[31:8] == 24'h000000);
            end
        end
    end

    // write strobes per register
    // strobes live in the data phase, where hwdata is valid; indices
    // without a strobe (read-only, reserved, unmapped) drop the write
    wire        wr_page;           // page chooser write
    wire        wr_vendor_swr;     // vendor page hard reset write
    wire        wr_ctrl;           // port control write
    wire        wr_mask;           // interrupt mask write
    reg  [2:0]  page_ff;           // page chooser field

    assign wr_page       = wr_now && hit_ff && (idx_ff == `IDX_PAGE_SEL);
    assign wr_ctrl       = wr_now && hit_ff && (idx_ff == `IDX_PORT_CTRL);
    assign wr_mask       = wr_now && hit_ff && (idx_ff == `IDX_IRQ_MASK);
    // only the vendor page decodes the hard reset byte
    assign wr_vendor_swr = wr_now && hit_ff && (idx_ff == `IDX_SOFT_RESET)
                           && (page_ff == `PAGE_VENDOR);

    // ------------------------------------------------------------
    // page chooser and software hard reset
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst_int) begin
            page_ff <= `RST_PAGE_SEL;
        end else if (wr_page) begin
            page_ff <= hwdata[`PAGE_SEL_LSB+2:`PAGE_SEL_LSB];
        end
    end

    // the bit is never stored, so it reads back as zero
    // registers take their reset values on the edge after the pulse,
    // so software leaves that cycle free of bus transfers
    always @(posedge ref_clk) begin
        if (rst_int) begin
            swr_pulse_ff <= 1'b0;
        end else begin
            swr_pulse_ff <= wr_vendor_swr && hwdata[`SWR_BIT];
        end
    end

    // offered to the port logic, which resets with the registers
    assign device_hard_reset = swr_pulse_ff;

    // ------------------------------------------------------------
    // per-port control: sleep allow and deep port off
    // ------------------------------------------------------------
    reg  [2:0]  sleep_allow_ff;    // per-port sleep allow
    reg  [2:0]  deep_off_ff;       // per-port deep port off
    wire [2:0]  deep_eff;          // deep off acting on a disabled port

    // strap sampled while reset is held, clocked so no async load
    // each reset edge reloads it, so a software reset re-reads the pin
    // and overrides whatever software wrote before
    always @(posedge ref_clk) begin
        if (rst_int) begin
            sleep_allow_ff <= {3{sleep_default_pin}};
            deep_off_ff    <= `RST_DEEP_OFF;
        end else if (wr_ctrl) begin
            sleep_allow_ff <= hwdata[`CTRL_SLEEP_LSB+2:`CTRL_SLEEP_LSB];
            deep_off_ff    <= hwdata[`CTRL_DEEP_LSB+2:`CTRL_DEEP_LSB];
        end
    end

    // a setting on an enabled port stays latent
    // and takes hold as soon as that port is disabled
    assign deep_eff = deep_off_ff & port_disabled;

    // tones stop only for hard-disabled ports
    // trade-off: lower power against losing ac connectivity status
    assign port_tone_enable = ~deep_eff;

    // forced flags; releasing deep off lets speed be renegotiated
    assign port_connected  = port_connected_raw  & ~deep_eff;
    assign receive_ok_flag = port_receive_ok_raw & ~deep_eff;

    // ------------------------------------------------------------
    // port state flags
    // ------------------------------------------------------------
    reg  [2:0]  sleeping_ff;       // sleep state per port
    reg  [2:0]  loop_break_ff;     // loop-disable flag per port
    reg  [2:0]  standby_ff;        // standby state per port
    reg  [2:0]  con_prev_ff;       // connected, one cycle late

    // sleep entered only with permission
    // withdrawing permission wakes the port on the next cycle
    always @(posedge ref_clk) begin
        if (rst_int) begin
            sleeping_ff <= 3'h0;
        end else begin
            sleeping_ff <= port_sleep_req & sleep_allow_ff;
        end
    end

    assign port_sleeping = sleeping_ff;

    // loop break: clear wins, a fresh detect next cycle re-sets it
    // the raw connection clears it, so a forced deep off on a port
    // does not count as a disconnect here
    always @(posedge ref_clk) begin
        if (rst_int) begin
            loop_break_ff <= 3'h0;
        end else if (bus_reset) begin
            loop_break_ff <= 3'h0;
        end else begin
            loop_break_ff <= (loop_break_ff | port_loop_detect)
                             & port_connected_raw;
        end
    end

    // standby mirror and connection history
    // history follows the forced flag, so a deep off raises the
    // disconnect event even though the cable stays plugged
    always @(posedge ref_clk) begin
        if (rst_int) begin
            standby_ff  <= 3'h0;
            con_prev_ff <= 3'h0;
        end else begin
            standby_ff  <= port_standby;
            con_prev_ff <= port_connected;
        end
    end

    // ------------------------------------------------------------
    // interrupts: sticky events, mask, clear on read
    // ------------------------------------------------------------
    reg  [2:0]  irq_stat_ff;       // sticky event bits
    reg  [2:0]  irq_mask_ff;       // enable per event
    reg  [2:0]  nxt_irq_stat;      // next sticky state
    wire [2:0]  ev;                // events this cycle
    wire        rd_irq;            // status read being captured

    // each event lasts about a cycle: it compares a condition with its flag
    assign ev[`IRQ_LOOP_BIT]  = |(port_loop_detect & port_connected_raw & ~loop_break_ff);
    assign ev[`IRQ_SLEEP_BIT] = |(port_sleep_req & sleep_allow_ff & ~sleeping_ff);
    assign ev[`IRQ_DISC_BIT]  = |(con_prev_ff & ~port_connected);
    assign rd_irq = rd_cap && hit_ff && (idx_ff == `IDX_IRQ_STAT);

    // a set in the clearing cycle survives
    // the clear lands on the capture edge, so what is read is what is
    // cleared; limitation: events merge across the three ports
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (rd_irq) begin
            nxt_irq_stat = 3'h0;
        end
        nxt_irq_stat = nxt_irq_stat | ev;
    end

    always @(posedge ref_clk) begin
        if (rst_int) begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= `RST_IRQ_MASK;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_mask) begin
                irq_mask_ff <= hwdata[2:0];
            end
        end
    end

    // level output: stays high until the status is read or masked off
    // a masked event still shows in the status for polling
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    reg  [31:0] rd_mux;            // read value for latched index

    // paged window decodes by page; other pages read zero
    // the index is latched, so the mux is steady through the wait cycle
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_ff) begin
            case (idx_ff)
                `IDX_PAGE_SEL: begin
                    rd_mux[`PAGE_SEL_LSB+2:`PAGE_SEL_LSB] = page_ff;
                end
                `IDX_PORT_CTRL: begin
                    rd_mux[`CTRL_SLEEP_LSB+2:`CTRL_SLEEP_LSB] = sleep_allow_ff;
                    rd_mux[`CTRL_DEEP_LSB+2:`CTRL_DEEP_LSB]   = deep_off_ff;
                end
                `IDX_PORT_STAT: begin
                    rd_mux[`STAT_SLEEP_LSB+2:`STAT_SLEEP_LSB]     = sleeping_ff;
                    rd_mux[`STAT_LOOP_LSB+2:`STAT_LOOP_LSB]       = loop_break_ff;
                    rd_mux[`STAT_STANDBY_LSB+2:`STAT_STANDBY_LSB] = standby_ff;
                end
                `IDX_PORT_LINK: begin
                    rd_mux[`LINK_CON_LSB+2:`LINK_CON_LSB]   = port_connected;
                    rd_mux[`LINK_RECEIVE_OK_FLAG_LSB+2:`LINK_RECEIVE_OK_FLAG_LSB] = receive_ok_flag;
                    rd_mux[`LINK_DIS_LSB+2:`LINK_DIS_LSB]   = port_disabled;
                end
                `IDX_IRQ_STAT: begin
                    rd_mux[2:0] = irq_stat_ff;
                end
                `IDX_IRQ_MASK: begin
                    rd_mux[2:0] = irq_mask_ff;
                end
                default: begin
                    rd_mux = 32'h00000000;
                end
            endcase
            // identification page; vendor page reads all zero
            if (page_ff == `PAGE_IDENT) begin
                case (idx_ff)
                    `IDX_COMPLIANCE:  rd_mux[7:0] = `COMPLIANCE_VALUE;
                    `IDX_IDENT_RSVD:  rd_mux[7:0] = 8'h00;
                    `IDX_OUI_HIGH:    rd_mux[7:0] = MAKER_OUI[23:16];
                    `IDX_OUI_MIDDLE:  rd_mux[7:0] = MAKER_OUI[15:8];
                    `IDX_OUI_LOW:     rd_mux[7:0] = MAKER_OUI[7:0];
                    `IDX_PART_HIGH:   rd_mux[7:0] = PART_CODE[23:16];
                    `IDX_PART_MIDDLE: rd_mux[7:0] = PART_CODE[15:8];
                    `IDX_PART_LOW:    rd_mux[7:0] = PART_CODE[7:0];
                    default:          rd_mux[7:0] = rd_mux[7:0];
                endcase
            end
        end
    end

    // hard reset bit never appears: vendor page reads zero
    // captured in the wait cycle so it sees every earlier write;
    // it then stands until the next read capture or the next pin or software reset
    always @(posedge ref_clk) begin
        if (rst_int) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_cap) begin
            rdata_ff <= rd_mux;
        end
    end

endmodule // phy_port_and_vendor_pages
`default_nettype wire

// ===== verif/llc_master.sv
// bus master model of the link-layer controller: single word transfers
`timescale 1ns/1ps
`default_nettype none
module llc_master (
    input  wire logic        ref_clk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    // bus idle at time zero
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

    // address phase held until ready, then data phase held until ready again
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? wd : 32'h0;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
endmodule // llc_master
`default_nettype wire

// ===== verif/phy_pages_sva.sv
// port-level checks of the paged phy register block
`timescale 1ns/1ps
`default_nettype none
module phy_pages_sva (
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [2:0] port_disabled,
    input wire logic [2:0] port_connected_raw,
    input wire logic [2:0] port_receive_ok_raw,
    input wire logic [2:0] port_sleep_req,
    input wire logic [2:0] port_sleeping,
    input wire logic [2:0] port_tone_enable,
    input wire logic [2:0] port_connected,
    input wire logic [2:0] receive_ok_flag,
    input wire logic       device_hard_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // transfer taken at this edge
    wire logic rd_req = hsel & htrans[1] & hready & !hwrite;
    wire logic wr_req = hsel & htrans[1] & hready & hwrite;
    // read answers after exactly one wait cycle
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (rd_req |=> s_read_wait) else $error("read wait wrong");
    a_write_nowait: assert property (wr_req |=> hreadyout) else $error("write stalled");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_sleep_gate: assert property (!(|(port_sleeping & ~$past(port_sleep_req)))) else $error("sleep no req");
    a_tone_gate: assert property (&(port_tone_enable | port_disabled)) else $error("tone off on live port");
    a_conn_forced: assert property (port_connected == (port_connected_raw & port_tone_enable))
        else $error("connected not forced");
    a_receive_ok_flag_forced: assert property (receive_ok_flag == (port_receive_ok_raw & port_tone_enable))
        else $error("receive ok not forced");
    a_hreset_pulse: assert property (device_hard_reset |=> !device_hard_reset) else $error("pulse too long");
    a_hreset_clear: assert property (device_hard_reset |=> port_tone_enable == 3'h7)
        else $error("deep off kept");
endmodule // phy_pages_sva
`default_nettype wire

// ===== verif/test_phy_port_and_vendor_pages.sv
// self-checking bench of the paged phy register block
`timescale 1ns/1ps
`default_nettype none
module test_phy_port_and_vendor_pages;
    localparam logic [47:0] IDS = {24'h123456, 24'h654321}; // arbitrary codes
    logic        ref_clk, nrst, sleep_default_pin, bus_reset;
    logic [2:0]  port_disabled, port_connected_raw, port_receive_ok_raw, port_loop_detect, port_standby, port_sleep_req;
    wire         hsel, hwrite, hreadyout, hresp, device_hard_reset, irq;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize, port_sleeping, port_tone_enable, port_connected, receive_ok_flag;
    int          num_errors = 0, total_checks = 0, cyc = 0;

    phy_port_and_vendor_pages #(.MAKER_OUI(IDS[47:24]), .PART_CODE(IDS[23:0])) u_dut (.ref_clk, .nrst, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .sleep_default_pin, .bus_reset, .port_disabled, .port_connected_raw, .port_receive_ok_raw,
        .port_loop_detect, .port_standby, .port_sleep_req, .port_sleeping, .port_tone_enable, .port_connected,
        .receive_ok_flag, .device_hard_reset, .irq);
    llc_master u_llc (.ref_clk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

    // free-running clock, 25 ns
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // hang guard well above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        logic [31:0] x;
        u_llc.xfer(1'b1, i, d, x);
    endtask
    task automatic rdc(input logic [5:0] i, input logic [31:0] e);
        logic [31:0] x;
        u_llc.xfer(1'b0, i, 32'h0, x);
        chk(x, e);
    endtask
    // identification page contents: level, reserved, maker then part, msb first
    function automatic logic [31:0] ident_exp(input logic [5:0] i);
        return (i == 6'h08) ? 32'h2 : (i == 6'h09) ? 32'h0 : {24'h0, IDS[8*(15-i) +: 8]};
    endfunction
    // status word: sleeping, loop break, standby
    function automatic logic [31:0] stat(input logic [2:0] slp, input logic [2:0] lp, input logic [2:0] sb);
        return {21'h0, sb, 1'b0, lp, 1'b0, slp};
    endfunction

    initial begin
        logic [31:0] r;
        logic [2:0]  d, s;
        logic        p;
        {nrst, bus_reset, port_disabled, port_connected_raw, port_receive_ok_raw} = '0;
        {port_loop_detect, port_standby, port_sleep_req} = '0;
        r = $urandom(43148);
        p = r[0];
        sleep_default_pin = p;
        step(5);
        nrst <= 1'b1;
        rdc(6'h10, {29'h0, {3{p}}});
        r = $urandom & 32'h7;
        wr(6'h10, $urandom | 32'h8);
        wr(6'h10, r);
        rdc(6'h10, r);
        wr(6'h11, 32'hffff);
        rdc(6'h11, 32'h0);
        rdc(6'h3f, 32'h0);
        s = $urandom;
        port_sleep_req <= 3'h7;
        port_standby <= s;
        step(2);
        chk(port_sleeping, r[2:0]);
        rdc(6'h11, stat(r[2:0], 3'h0, s));
        d = $urandom;
        port_disabled <= d;
        port_connected_raw <= 3'h7;
        port_receive_ok_raw <= 3'h7;
        wr(6'h10, r | 32'h70);
        step(1);
        chk(port_connected, {29'h0, ~d});
        chk(receive_ok_flag, {29'h0, ~d});
        chk(port_tone_enable, {29'h0, ~d});
        rdc(6'h12, {21'h0, d, 1'b0, ~d, 1'b0, ~d});
        wr(6'h10, r);
        step(1);
        chk(port_connected, 3'h7);
        port_disabled <= 3'h0;
        port_loop_detect <= 3'h2;
        step(1);
        port_loop_detect <= 3'h0;
        step(2);
        rdc(6'h11, stat(r[2:0], 3'h2, s));
        bus_reset <= 1'b1;
        step(1);
        bus_reset <= 1'b0;
        port_loop_detect <= 3'h4;
        step(1);
        port_loop_detect <= 3'h0;
        step(2);
        rdc(6'h11, stat(r[2:0], 3'h4, s));
        port_connected_raw <= 3'h3;
        step(2);
        rdc(6'h11, stat(r[2:0], 3'h0, s));
        port_connected_raw <= 3'h7;
        rdc(6'h13, {29'h0, 1'b1, |r, 1'b1});
        for (int m = 1; m >= 0; m--) begin
            wr(6'h14, m);
            rdc(6'h14, m);
            port_loop_detect <= 3'h1;
            step(1);
            port_loop_detect <= 3'h0;
            step(3);
            chk(irq, m);
            rdc(6'h13, 32'h1);
            step(1);
            chk(irq, 1'b0);
            bus_reset <= 1'b1;
            step(1);
            bus_reset <= 1'b0;
        end
        wr(6'h07, 32'h1);
        for (int i = 8; i < 16; i++) rdc(6'(i), ident_exp(6'(i)));
        wr(6'h0a, $urandom);
        rdc(6'h0a, ident_exp(6'h0a));
        wr(6'h07, 32'h2);
        rdc(6'h08, 32'h0);
        wr(6'h07, 32'h7);
        for (int i = 8; i < 16; i++) rdc(6'(i), 32'h0);
        sleep_default_pin <= ~p;
        port_disabled <= 3'h7;
        wr(6'h10, 32'h70);
        wr(6'h0e, 32'h80);
        step(3);
        chk(port_tone_enable, 32'h7);
        rdc(6'h07, 32'h0);
        rdc(6'h10, {29'h0, {3{~p}}});
        final_report();
    end
endmodule // test_phy_port_and_vendor_pages

bind phy_port_and_vendor_pages phy_pages_sva u_sva (.ref_clk, .nrst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .port_disabled, .port_connected_raw, .port_receive_ok_raw, .port_sleep_req, .port_sleeping,
    .port_tone_enable, .port_connected, .receive_ok_flag, .device_hard_reset);
`default_nettype wire
